// *** hdl/caf_filter.v ***
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "caf_map.vh"
module caf_filter #(
  parameter MB_N  = 16,
  parameter MB_AW = 4
) (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire [5:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        rx_valid_i,
  input  wire [28:0] rx_id_i,
  input  wire        rx_ide_i,
  input  wire        rx_rtr_i,
  output reg         acc_valid_o,
  output reg         acc_ok_o,
  output reg  [4:0]  acc_mb_o
);
  // ----------------------------------------
  // control state
  // ----------------------------------------
  reg  [1:0]  mode_r;
  reg  [1:0]  pre_sleep_r;
  reg  [1:0]  id_format_select_r;
  reg         fifo_mode_r;
  reg  [15:0] mask_invalid_select_r;
  reg  [30:0] id_mask_reg_r [0:3];
  reg  [30:0] fifo_rx_id_compare_r [0:1];
  reg  [10:0] filter_support_id_r;
  reg  [28:0] cap_id_r;
  reg         cap_ide_r;
  reg         cap_rtr_r;
  reg  [1:0]  st_r;
  reg  [MB_AW:0] idx_r;
  reg         hit_r;
  reg  [4:0]  hit_mb_r;
  reg         bus_busy_r;
  wire [30:0] mb_rd_data;
  wire        awake = (mode_r != `CAF_MODE_SLEEP);
  localparam ST_IDLE = 2'h0;
  localparam ST_SCAN = 2'h1;
  localparam ST_CMP  = 2'h2;
  localparam ST_DONE = 2'h3;
  localparam [4:0] FIFO_MB = MB_N - 4;
  wire        rx_take = rx_valid_i && awake && (st_r == ST_IDLE);
  // ----------------------------------------
  // mailbox id storage
  // ----------------------------------------
  wire mb_wr = bus_busy_r && avs_write_i && awake && (avs_address_i[5:4] == 2'h1);
  caf_reg_ram #(.DW(`CAF_CMP_W), .AW(MB_AW)) u_mbid (
    .clk_sys_i (clk_sys_i),
    .wr_en_i   (mb_wr),
    .wr_addr_i (avs_address_i[MB_AW-1:0]),
    .wr_data_i (avs_writedata_i[30:0]),
    .rd_addr_i (idx_r[MB_AW-1:0]),
    .rd_data_o (mb_rd_data)
  );
  // ----------------------------------------
  // compare vector and match
  // ----------------------------------------
  wire [30:0] rx_vec = {cap_ide_r, cap_rtr_r, cap_id_r};
  wire [30:0] ide_keep = (id_format_select_r == `CAF_ID_FORMAT_SELECT_MIXED) ?
                         31'h7FFFFFFF : 31'h3FFFFFFF;
  function match;
    input [30:0] a;
    input [30:0] b;
    input [30:0] m;
    input [30:0] k;
    begin
      match = (((a ^ b) & m & k) == 31'h00000000);
    end
  endfunction
  wire        scan_mb   = idx_r[MB_AW-1:0] < (fifo_mode_r ? MB_N - 4 : MB_N);
  wire [1:0]  mask_sel  = (idx_r[MB_AW-1:0] >= MB_N - 4) ? 2'h3 : 2'h0;
  wire [30:0] mb_mask   = mask_invalid_select_r[idx_r[MB_AW-1:0]] ?
                          31'h7FFFFFFF : id_mask_reg_r[mask_sel];
  // ----------------------------------------
  // two fifo filters
  // ----------------------------------------
  wire [1:0]  fifo_hit_v;
  genvar      g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_fifo
      assign fifo_hit_v[g] = match(rx_vec, fifo_rx_id_compare_r[g], id_mask_reg_r[g+2],
                                   ide_keep);
    end
  endgenerate
  wire        fifo_hit  = |fifo_hit_v;
  // ----------------------------------------
  // receive filter sequencer
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r                <= ST_IDLE;
      idx_r               <= {(MB_AW+1){1'b0}};
      cap_id_r            <= 29'h0000000;
      cap_ide_r           <= 1'b0;
      cap_rtr_r           <= 1'b0;
      hit_r               <= 1'b0;
      hit_mb_r            <= 5'h00;
      acc_valid_o         <= 1'b0;
      acc_ok_o            <= 1'b0;
      acc_mb_o            <= 5'h00;
    end
    else if (!awake)
      acc_valid_o <= 1'b0;
    else
    begin
      acc_valid_o <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (rx_valid_i && awake)
          begin
            cap_id_r            <= rx_id_i;
            cap_ide_r           <= rx_ide_i;
            cap_rtr_r           <= rx_rtr_i;
            idx_r               <= {(MB_AW+1){1'b0}};
            hit_r               <= 1'b0;
            st_r                <= ST_SCAN;
          end
        end
        ST_SCAN:
          st_r <= ST_CMP;
        ST_CMP:
        begin
          if (!hit_r && idx_r < MB_N && scan_mb &&
              match(rx_vec, mb_rd_data, mb_mask, ide_keep))
          begin
            hit_r    <= 1'b1;
            hit_mb_r <= idx_r[4:0];
          end
          if (idx_r == MB_N - 1 || hit_r)
            st_r <= ST_DONE;
          else
          begin
            idx_r <= idx_r + 1'b1;
            st_r  <= ST_SCAN;
          end
        end
        ST_DONE:
        begin
          acc_valid_o <= 1'b1;
          if (!hit_r && fifo_mode_r && fifo_hit)
          begin
            acc_ok_o <= 1'b1;
            acc_mb_o <= FIFO_MB;
          end
          else
          begin
            acc_ok_o <= hit_r;
            acc_mb_o <= hit_mb_r;
          end
          st_r <= ST_IDLE;
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // support register capture and decode
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      filter_support_id_r <= 11'h000;
    else if (rx_take)
      filter_support_id_r <= rx_id_i[28:18];
  end
  wire [7:0] low_hot;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_hot
      assign low_hot[g] = (filter_support_id_r[2:0] == g);
    end
  endgenerate
  wire [15:0] support_rd = {filter_support_id_r[10:3], low_hot};
  // ----------------------------------------
  // avalon slave: take, answer one cycle later
  // ----------------------------------------
  integer     i;
  reg  [31:0] rd_mux;
  wire        bus_take = (avs_read_i || avs_write_i) && !bus_busy_r;
  wire        wr_go    = bus_busy_r && avs_write_i;
  wire        ctrl_go  = wr_go && (avs_address_i == `CAF_A_CTRL);
  wire        cfg_go   = wr_go && awake;
  always @*
  begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      `CAF_A_CTRL:
        rd_mux = {27'h0000000, fifo_mode_r, id_format_select_r, mode_r};
      `CAF_A_MSKINV:
        rd_mux = {16'h0000, mask_invalid_select_r};
      `CAF_A_SUPPORT:
        rd_mux = {16'h0000, support_rd};
      `CAF_A_STATUS:
        rd_mux = {24'h000000, pre_sleep_r, acc_ok_o, acc_mb_o};
      `CAF_A_FIFOCMP0:
        rd_mux = {1'b0, fifo_rx_id_compare_r[0]};
      `CAF_A_FIFOCMP1:
        rd_mux = {1'b0, fifo_rx_id_compare_r[1]};
      default:
      begin
        if (avs_address_i[5:2] == 4'h2)
          rd_mux = {1'b0, id_mask_reg_r[avs_address_i[1:0]]};
      end
    endcase
  end
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
      bus_busy_r        <= 1'b0;
    end
    else if (bus_busy_r)
    begin
      bus_busy_r        <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end
    else if (bus_take)
    begin
      bus_busy_r        <= 1'b1;
      avs_waitrequest_o <= 1'b0;
      if (avs_read_i)
        avs_readdata_o <= rd_mux;
    end
  end
  // ----------------------------------------
  // control register, sleep entry and return
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_r             <= `CAF_MODE_RESET;
      pre_sleep_r        <= `CAF_MODE_RESET;
      id_format_select_r <= 2'h0;
      fifo_mode_r        <= 1'b0;
    end
    else if (ctrl_go)
    begin
      if (avs_writedata_i[1:0] == `CAF_MODE_SLEEP)
      begin
        if (mode_r == `CAF_MODE_RESET || mode_r == `CAF_MODE_HALT)
        begin
          pre_sleep_r <= mode_r;
          mode_r      <= `CAF_MODE_SLEEP;
        end
      end
      else if (mode_r == `CAF_MODE_SLEEP)
        mode_r <= pre_sleep_r;
      else
      begin
        mode_r             <= avs_writedata_i[1:0];
        id_format_select_r <= avs_writedata_i[3:2];
        fifo_mode_r        <= avs_writedata_i[4];
      end
    end
  end
  // ----------------------------------------
  // filter configuration, frozen in sleep
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mask_invalid_select_r   <= 16'h0000;
      for (i = 0; i < 4; i = i + 1)
        id_mask_reg_r[i] <= 31'h00000000;
      fifo_rx_id_compare_r[0] <= 31'h00000000;
      fifo_rx_id_compare_r[1] <= 31'h00000000;
    end
    else if (cfg_go)
    begin
      if (avs_address_i == `CAF_A_MSKINV)
        mask_invalid_select_r <= avs_writedata_i[15:0];
      else if (avs_address_i == `CAF_A_FIFOCMP0)
        fifo_rx_id_compare_r[0] <= avs_writedata_i[30:0];
      else if (avs_address_i == `CAF_A_FIFOCMP1)
        fifo_rx_id_compare_r[1] <= avs_writedata_i[30:0];
      else if (avs_address_i[5:2] == 4'h2)
        id_mask_reg_r[avs_address_i[1:0]] <= avs_writedata_i[30:0];
    end
  end
endmodule // caf_filter

// *** hdl/caf_map.vh ***
// Contract
// - identifiers are 11-bit standard or 29-bit extended format.
// - hardware accepts (1, stored) or discards (0) every received message; here one arriving outside ST_IDLE gets no decision.
// - normal mailboxes filter with mask and stored id; per-mailbox mask invalid bit.
// - mask bit 1 compares that id bit; mask bit 0 ignores it.
// - compare covers rtr and ide bits as well as id bits.
// - ide bit compared only when id format select is mixed mode 10b.
// - fifo mode applies two filters using masks two, three and two fifo compares.
// - fifo acceptance compares against fifo compare registers, not mailbox id.
// - support unit serves standard identifiers only.
// - each received message writes its id into the support register; here one arriving while the sequencer is not in ST_IDLE leaves it unchanged.
// - support read gives upper 8 id bits and low 3 bits one-hot decoded.
// - sleep mode stops all module operation; here Avalon reads and the control register write that leaves sleep still work.
// - leaving sleep returns to the reset or halt mode held before.
`ifndef CAF_MAP_VH
`define CAF_MAP_VH
// ----------------------------------------
// register word offsets (byte address / 4)
// ----------------------------------------
`define CAF_A_CTRL      6'h00
`define CAF_A_MSKINV    6'h01
`define CAF_A_SUPPORT   6'h02
`define CAF_A_STATUS    6'h03
`define CAF_A_FIFOCMP0  6'h04
`define CAF_A_FIFOCMP1  6'h05
`define CAF_A_MASK0     6'h08
`define CAF_A_MBID0     6'h10
// ----------------------------------------
// fields
// ----------------------------------------
`define CAF_ID_W        29
`define CAF_CMP_W       31
`define CAF_IDE_BIT     30
`define CAF_RTR_BIT     29
`define CAF_ID_FORMAT_SELECT_MIXED  2'h2
`define CAF_MODE_OPER   2'h0
`define CAF_MODE_RESET  2'h1
`define CAF_MODE_HALT   2'h2
`define CAF_MODE_SLEEP  2'h3
`define CAF_CTRL_RST    32'h00000001
`endif

// *** hdl/caf_reg_ram.v ***
`timescale 1ns/1ps
module caf_reg_ram #(
  parameter DW = 31,
  parameter AW = 4
) (
  input  wire          clk_sys_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  input  wire [AW-1:0] rd_addr_i,
  output reg  [DW-1:0] rd_data_o
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];
  // ----------------------------------------
  // write port, registered read port
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (wr_en_i)
      mem_r[wr_addr_i] <= wr_data_i;
    rd_data_o <= mem_r[rd_addr_i];
  end
endmodule // caf_reg_ram

// *** tb/caf_filter_asserts.sv ***
`timescale 1ns/1ps
module caf_filter_chk #(
  parameter MB_N  = 16,
  parameter MB_AW = 4
) (
  input wire        clk_sys_i,
  input wire        rst_n_i,
  input wire [5:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        rx_valid_i,
  input wire [28:0] rx_id_i,
  input wire        acc_valid_o,
  input wire        acc_ok_o,
  input wire [4:0]  acc_mb_o
);
  // ----------------------------------------
  // shadow of mode, sleep and support id
  // ----------------------------------------
  wire       ack   = !avs_waitrequest_o;
  wire       ctl_w = ack && avs_write_i && (avs_address_i == 6'h00);
  wire       ctl_r = ack && avs_read_i && (avs_address_i == 6'h00);
  wire       sup_a = ack && avs_read_i && (avs_address_i == 6'h02);
  reg        busy_r;
  reg        slp_r;
  reg [1:0]  mode_r;
  reg [10:0] sup_r;
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      busy_r <= 1'b0;
      slp_r  <= 1'b0;
      mode_r <= 2'h1;
      sup_r  <= 11'h000;
    end
    else
    begin
      if (acc_valid_o)
        busy_r <= 1'b0;
      if (rx_valid_i && (!busy_r || acc_valid_o) && !slp_r)
      begin
        busy_r <= 1'b1;
        sup_r  <= rx_id_i[28:18];
      end
      if (ctl_w && (avs_writedata_i[1:0] == 2'h3))
      begin
        if (mode_r == 2'h1 || mode_r == 2'h2)
          slp_r <= 1'b1;
      end
      else if (ctl_w && slp_r)
        slp_r <= 1'b0;
      else if (ctl_w)
        mode_r <= avs_writedata_i[1:0];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_pulse; acc_valid_o |=> !acc_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("decision pulse too long");
  property p_cause; acc_valid_o |-> busy_r; endproperty
  a_cause: assert property (p_cause) else $error("decision without id");
  sequence s_taken; rx_valid_i && (!busy_r || acc_valid_o) && !slp_r; endsequence
  sequence s_done; ##[1:40] acc_valid_o; endsequence
  property p_decide; s_taken |-> s_done; endproperty
  a_decide: assert property (p_decide) else $error("no decision");
  property p_hold; !acc_valid_o |-> $stable(acc_ok_o) && $stable(acc_mb_o); endproperty
  a_hold: assert property (p_hold) else $error("result changed");
  property p_mb; acc_valid_o && acc_ok_o |-> acc_mb_o < MB_N; endproperty
  a_mb: assert property (p_mb) else $error("mailbox out of range");
  property p_sup; sup_a |-> avs_readdata_o == {16'h0000, sup_r[10:3], 8'h01 << sup_r[2:0]}; endproperty
  a_sup: assert property (p_sup) else $error("support word wrong");
  property p_sleep; slp_r |-> !acc_valid_o; endproperty
  a_sleep: assert property (p_sleep) else $error("decision in sleep");
  property p_mode; ctl_r && !slp_r |-> avs_readdata_o[1:0] == mode_r; endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
endmodule // caf_filter_chk

bind caf_filter caf_filter_chk #(.MB_N(MB_N), .MB_AW(MB_AW)) u_caf_filter_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i), .acc_valid_o(acc_valid_o),
  .acc_ok_o(acc_ok_o), .acc_mb_o(acc_mb_o)
);

// *** tb/caf_rx_node.sv ***
`timescale 1ns/1ps
module caf_rx_node (
  input  wire        clk_sys_i,
  output reg         rx_valid_o = 1'b0,
  output reg  [28:0] rx_id_o    = 29'h0,
  output reg         rx_ide_o   = 1'b0,
  output reg         rx_rtr_o   = 1'b0
);
  // ----------------------------------------
  // one received frame id, then scrambled
  // ----------------------------------------
  task send(input [28:0] id, input ide, input rtr);
  begin
    rx_valid_o <= 1'b1;
    rx_id_o    <= id;
    rx_ide_o   <= ide;
    rx_rtr_o   <= rtr;
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b0;
    rx_id_o    <= ~id;
    rx_ide_o   <= ~ide;
    rx_rtr_o   <= ~rtr;
  end
  endtask
endmodule // caf_rx_node

// *** tb/caf_filter_tb.sv ***
`timescale 1ns/1ps
module caf_filter_tb;
  reg         clk_sys_i       = 1'b0;
  reg         rst_n_i         = 1'b0;
  reg  [5:0]  avs_address_i   = 6'h00;
  reg         avs_read_i      = 1'b0;
  reg         avs_write_i     = 1'b0;
  reg  [31:0] avs_writedata_i = 32'h0;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o;
  wire        rx_valid_i;
  wire        rx_ide_i;
  wire        rx_rtr_i;
  wire [28:0] rx_id_i;
  wire        acc_valid_o;
  wire        acc_ok_o;
  wire [4:0]  acc_mb_o;
  reg  [31:0] q;
  reg  [7:0]  tbl [0:255];
  integer     n_fail = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  integer     i;
  integer     seen;
  always #2 clk_sys_i = ~clk_sys_i;
  caf_filter u_caf_filter (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i), .rx_ide_i(rx_ide_i), .rx_rtr_i(rx_rtr_i),
    .acc_valid_o(acc_valid_o), .acc_ok_o(acc_ok_o), .acc_mb_o(acc_mb_o)
  );
  caf_rx_node u_caf_rx_node (
    .clk_sys_i(clk_sys_i), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i),
    .rx_ide_o(rx_ide_i), .rx_rtr_o(rx_rtr_i)
  );
  // ----------------------------------------
  // bus, receive and compare tasks
  // ----------------------------------------
  task close_out;
  begin
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task bus(input w, input [5:0] a, input [31:0] d);
  begin
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_sys_i);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_sys_i);
  end
  endtask
  task rx(input [28:0] id, input ide, input rtr, input ok, input [4:0] mb);
  begin
    u_caf_rx_node.send(id, ide, rtr);
    while (acc_valid_o !== 1'b1)
      @(posedge clk_sys_i);
    chk(acc_ok_o, ok);
    if (ok)
      chk(acc_mb_o, mb);
    @(posedge clk_sys_i);
  end
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial
  begin
    for (i = 0; i < 256; i = i + 1)
      tbl[i] = 8'h00;
    tbl[8'h24] = 8'h08;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    bus(0, 6'h00, 0);
    chk(q[1:0], 2'h1);
    bus(0, 6'h3F, 0);
    chk(q, 0);
    bus(1, 6'h00, 32'h0);
    bus(1, 6'h08, 32'h7FFC0000);
    bus(1, 6'h0B, 32'h7FFC0000);
    for (i = 0; i < 16; i = i + 1)
      bus(1, 6'h10 + i[5:0], (i ? i : 32'h123) << 18);
    rx({11'h123, 18'h0}, 0, 0, 1, 0);
    rx({11'h123, 18'h0}, 0, 1, 0, 0);
    rx({11'h122, 18'h0}, 0, 0, 0, 0);
    rx({11'h005, 18'h0}, 0, 0, 1, 5);
    rx({11'h00D, 18'h0}, 0, 0, 1, 13);
    rx({11'h123, 18'h0}, 1, 0, 1, 0);
    $display("test basic done");
    bus(1, 6'h00, 32'h8);
    rx({11'h123, 18'h0}, 1, 0, 0, 0);
    bus(1, 6'h08, 32'h7FF80000);
    rx({11'h122, 18'h0}, 0, 0, 1, 0);
    bus(1, 6'h11, 32'h52345678);
    bus(1, 6'h01, 32'h3);
    rx(29'h12345678, 1, 0, 1, 1);
    rx({11'h122, 18'h0}, 0, 0, 0, 0);
    $display("test mask done");
    bus(1, 6'h00, 32'h18);
    bus(1, 6'h04, 32'h08000000);
    bus(1, 6'h05, 32'h0C000000);
    bus(1, 6'h0A, 32'h7FFC0000);
    rx({11'h200, 18'h0}, 0, 0, 1, 12);
    rx({11'h300, 18'h0}, 0, 0, 1, 12);
    rx({11'h301, 18'h0}, 0, 0, 0, 0);
    rx({11'h123, 18'h0}, 0, 0, 1, 0);
    bus(0, 6'h02, 0);
    chk(q, 32'h00002408);
    chk((tbl[q[15:8]] & q[7:0]) != 8'h00, 1);
    $display("test fifo done");
    bus(1, 6'h00, 32'h12);
    bus(1, 6'h00, 32'h13);
    u_caf_rx_node.send({11'h123, 18'h0}, 0, 0);
    seen = 0;
    repeat (40)
    begin
      @(posedge clk_sys_i);
      if (acc_valid_o === 1'b1)
        seen = 1;
    end
    chk(seen, 0);
    bus(1, 6'h00, 32'h10);
    bus(0, 6'h00, 0);
    chk(q[1:0], 2'h2);
    bus(0, 6'h03, 0);
    chk(q, 32'h000000A0);
    bus(1, 6'h00, 32'h11);
    bus(1, 6'h00, 32'h13);
    bus(1, 6'h01, 32'hFFFF);
    bus(1, 6'h00, 32'h10);
    bus(0, 6'h00, 0);
    chk(q[1:0], 2'h1);
    bus(0, 6'h01, 0);
    chk(q, 32'h00000003);
    $display("test sleep done");
    close_out;
  end
endmodule // caf_filter_tb
